// [hw/smsp_pkg.sv]
// Constants and types of the serial master/slave port
package smsp_pkg;

   // -------------------------------------------------------------------
   // Sizes and counts
   // -------------------------------------------------------------------
   localparam int unsigned SMSP_DW = 8;
   // Sixteen clock edges make one byte, counted 0 to 15
   localparam logic [4:0] SMSP_EDGE_LAST = 5'h0f;
   // Fastest master rate is fCPU/4: two CPU cycles per clock half
   localparam logic [6:0] SMSP_HALF_MIN = 7'h02;
   // Six rates, codes 0 to 5; higher codes run at the slowest rate
   localparam logic [2:0] SMSP_RATE_MAX = 3'h5;
   localparam logic [1:0] SMSP_SYNC_RST = 2'h0;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      SMSP_IDLE = 3'b001,
      SMSP_WAIT = 3'b010,
      SMSP_RUN  = 3'b100
   } smsp_state_e;

   typedef struct packed {
      smsp_state_e state;
      logic master_select;
      logic periph_enable;
      logic cpol;
      logic cpha;
      logic [2:0] rate;
      logic transfer_irq_enable;
      logic select_sw_manage;
      logic select_sw_level;
      logic [7:0] sh;
      logic out_bit;
      logic [4:0] edges;
      logic [6:0] div;
      logic sck;
      logic sck_prev;
      logic transfer_done_flag;
      logic csr_seen;
      logic overrun_flag;
      logic write_collision_flag;
      logic mode_fault_flag;
      logic mode_fault_flag_seen;
      logic irq;
      logic sck_oe;
      logic mosi_oe;
      logic miso_oe;
      logic push;
      logic [7:0] push_data;
   } smsp_core_s;

   typedef struct packed {
      logic [7:0] head;
      logic [7:0] tail;
      logic head_v;
      logic tail_v;
   } smsp_buf_s;

   // -------------------------------------------------------------------
   // Values after reset
   // -------------------------------------------------------------------
   localparam smsp_core_s SMSP_CORE_RST = '{state: SMSP_IDLE, default: '0};
   localparam smsp_buf_s SMSP_BUF_RST = '0;

endpackage

// [hw/smsp_buf2.sv]
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/1ns
module smsp_buf2 (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   input wire logic [7:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [7:0] o_out_data,
   input wire logic i_out_ready
);

   smsp_pkg::smsp_buf_s q;
   smsp_pkg::smsp_buf_s n;

   // -------------------------------------------------------------------
   // Pop first, then push into the first free slot
   // -------------------------------------------------------------------
   always_comb begin
      n = q;
      if (q.head_v && i_out_ready) begin
         n.head = q.tail;
         n.head_v = q.tail_v;
         n.tail_v = 1'b0;
      end
      if (i_in_valid && !q.tail_v) begin
         if (!n.head_v) begin
            n.head = i_in_data;
            n.head_v = 1'b1;
         end else begin
            n.tail = i_in_data;
            n.tail_v = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= smsp_pkg::SMSP_BUF_RST;
      end else begin
         q <= n;
      end
   end

   assign o_in_ready = !q.tail_v;
   assign o_out_valid = q.head_v;
   assign o_out_data = q.head;

endmodule

// [hw/smsp_port.sv]
// Serial master/slave port: shift engine, flags and receive buffer
`timescale 1ns/1ns
module smsp_port (
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_ctrl_write,
   input wire logic i_master_select,
   input wire logic i_periph_enable,
   input wire logic i_transfer_irq_enable,
   input wire logic i_cpol,
   input wire logic i_cpha,
   input wire logic [2:0] i_clock_rate_sel,
   input wire logic i_csr_write,
   input wire logic i_select_sw_manage,
   input wire logic i_select_sw_level,
   input wire logic i_csr_access,
   input wire logic i_dr_write,
   input wire logic [7:0] i_dr_wdata,
   input wire logic i_dr_read,
   input wire logic i_cpu_irq_mask,
   input wire logic i_rx_ready,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_transfer_done_flag,
   output logic o_overrun_flag,
   output logic o_write_collision_flag,
   output logic o_mode_fault_flag,
   output logic o_master_active,
   output logic o_irq,
   input wire logic i_ss_n,
   input wire logic i_sck,
   output logic o_sck,
   output logic o_sck_oe,
   input wire logic i_mosi,
   output logic o_mosi,
   output logic o_mosi_oe,
   input wire logic i_miso,
   output logic o_miso,
   output logic o_miso_oe
);

   // -------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_q <= smsp_pkg::SMSP_SYNC_RST;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // -------------------------------------------------------------------
   // State and decode
   // -------------------------------------------------------------------
   smsp_pkg::smsp_core_s q;
   smsp_pkg::smsp_core_s n;
   logic ss_int;
   logic master_on;
   logic slave_on;
   logic busy;
   logic inhibit;
   logic clr_done;
   logic edge_ev;
   logic new_sck;
   logic lead;
   logic din;
   logic fin;
   logic [2:0] rate_c;
   logic [6:0] half;
   logic buf_ready;

   always_comb begin
      n = q;
      n.push = 1'b0;
      edge_ev = 1'b0;
      new_sck = q.sck;
      lead = 1'b0;
      fin = 1'b0;
      // Internal select from pin or software level
      // software select override
      ss_int = q.select_sw_manage ? q.select_sw_level : i_ss_n;
      master_on = q.master_select && q.periph_enable;
      slave_on = !q.master_select && q.periph_enable;
      din = q.master_select ? i_miso : i_mosi;
      rate_c = (q.rate > smsp_pkg::SMSP_RATE_MAX) ?
               smsp_pkg::SMSP_RATE_MAX : q.rate;
      half = 7'(smsp_pkg::SMSP_HALF_MIN << rate_c);
      busy = (q.state != smsp_pkg::SMSP_IDLE) ||
             (slave_on && !q.cpha && !ss_int);
      // writes held off until status read
      inhibit = q.transfer_done_flag && !q.csr_seen;
      clr_done = q.csr_seen && (i_dr_read || (!q.master_select && i_dr_write));

      // Configuration writes; fault blocks enables outside its clearing
      if (i_ctrl_write) begin
         n.cpol = i_cpol;
         n.cpha = i_cpha;
         n.rate = i_clock_rate_sel;
         n.transfer_irq_enable = i_transfer_irq_enable;
         n.master_select = i_master_select && (!q.mode_fault_flag || q.mode_fault_flag_seen);
         n.periph_enable = i_periph_enable && (!q.mode_fault_flag || q.mode_fault_flag_seen);
         if (q.mode_fault_flag_seen) begin
            n.mode_fault_flag = 1'b0;
            n.mode_fault_flag_seen = 1'b0;
         end
      end
      if (i_csr_write) begin
         n.select_sw_manage = i_select_sw_manage;
         n.select_sw_level = i_select_sw_level;
      end
      if (i_csr_access) begin
         n.overrun_flag = 1'b0;
         if (q.mode_fault_flag) begin
            n.mode_fault_flag_seen = 1'b1;
         end
         if (q.transfer_done_flag || q.write_collision_flag) begin
            n.csr_seen = 1'b1;
         end
      end
      if (clr_done) begin
         n.transfer_done_flag = 1'b0;
         n.write_collision_flag = 1'b0;
         n.csr_seen = 1'b0;
      end

      // Data register write: load, collide or ignore
      if (i_dr_write && !inhibit) begin
         if (busy) begin
            n.write_collision_flag = 1'b1;
         end else begin
            n.sh = i_dr_wdata;
            if (master_on) begin
               n.state = smsp_pkg::SMSP_WAIT;
            end
         end
      end

      unique case (q.state)
         smsp_pkg::SMSP_IDLE: begin
            // slave starts on the master's first edge
            if (slave_on && !ss_int && (i_sck != q.sck_prev)) begin
               n.state = smsp_pkg::SMSP_RUN;
            end
         end
         smsp_pkg::SMSP_WAIT: begin
            // Start only when the receive buffer has room
            if (buf_ready) begin
               n.state = smsp_pkg::SMSP_RUN;
               n.div = '0;
               n.edges = '0;
               n.out_bit = q.sh[7];
            end
         end
         smsp_pkg::SMSP_RUN: begin
         end
      endcase

      // Clock edges: generated as master, sampled as slave
      if (q.state == smsp_pkg::SMSP_RUN && q.master_select) begin
         if (q.div == half - 7'h01) begin
            n.div = '0;
            new_sck = !q.sck;
            edge_ev = 1'b1;
         end else begin
            n.div = q.div + 7'h01;
         end
      end else if (slave_on && !ss_int) begin
         new_sck = i_sck;
         edge_ev = (i_sck != q.sck_prev);
      end
      n.sck_prev = i_sck;

      if (edge_ev) begin
         n.sck = new_sck;
         // polarity and phase pick the sampling edge
         lead = (new_sck != q.cpol);
         if (lead != q.cpha) begin
            // shift in, most significant bit first
            n.sh = {q.sh[6:0], din};
         end else begin
            n.out_bit = q.sh[7];
         end
         n.edges = q.edges + 5'h01;
         if (q.edges == smsp_pkg::SMSP_EDGE_LAST) begin
            fin = 1'b1;
         end
      end

      // Phase-0 slave presents its first bit before any edge
      if (slave_on && !q.cpha && n.state == smsp_pkg::SMSP_IDLE) begin
         n.out_bit = n.sh[7];
      end

      if (fin) begin
         n.state = smsp_pkg::SMSP_IDLE;
         n.edges = '0;
         n.transfer_done_flag = 1'b1;
         if ((q.transfer_done_flag && !clr_done) || !buf_ready) begin
            n.overrun_flag = 1'b1;
         end else begin
            n.push = 1'b1;
            n.push_data = n.sh;
         end
      end

      // Master with select low loses its mode
      // mode fault
      if (master_on && !ss_int) begin
         n.mode_fault_flag = 1'b1;
         n.master_select = 1'b0;
         n.periph_enable = 1'b0;
      end
      if (!n.periph_enable) begin
         n.state = smsp_pkg::SMSP_IDLE;
         n.edges = '0;
      end

      if (!(n.master_select && n.state == smsp_pkg::SMSP_RUN)) begin
         n.sck = n.cpol;
      end
      n.sck_oe = n.master_select && n.periph_enable;
      n.mosi_oe = n.master_select && n.periph_enable;
      n.miso_oe = !n.master_select && n.periph_enable && !ss_int;
      // interrupt gated by enable and CPU mask
      n.irq = (n.transfer_done_flag || n.mode_fault_flag || n.overrun_flag) && n.transfer_irq_enable && !i_cpu_irq_mask;
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= smsp_pkg::SMSP_CORE_RST;
      end else begin
         q <= n;
      end
   end

   // -------------------------------------------------------------------
   // Receive buffer
   // -------------------------------------------------------------------
   smsp_buf2 u_rx_buf (
      .i_clk(i_sys_clk),
      .i_rst_n(rst_n),
      .i_in_valid(q.push),
      .i_in_data(q.push_data),
      .o_in_ready(buf_ready),
      .o_out_valid(o_rx_valid),
      .o_out_data(o_rx_data),
      .i_out_ready(i_rx_ready)
   );

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign o_transfer_done_flag = q.transfer_done_flag;
   assign o_overrun_flag = q.overrun_flag;
   assign o_write_collision_flag = q.write_collision_flag;
   assign o_mode_fault_flag = q.mode_fault_flag;
   assign o_master_active = q.master_select;
   assign o_irq = q.irq;
   assign o_sck = q.sck;
   assign o_sck_oe = q.sck_oe;
   assign o_mosi = q.out_bit;
   assign o_mosi_oe = q.mosi_oe;
   assign o_miso = q.out_bit;
   assign o_miso_oe = q.miso_oe;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence m_start_s;
      q.state == smsp_pkg::SMSP_RUN && q.master_select &&
      $past(q.state) == smsp_pkg::SMSP_WAIT;
   endsequence

   sequence m_fast_s;
      m_start_s ##0 (q.rate == 3'h0);
   endsequence

   idle_clock_a: assert property (
      (q.sck_oe && q.state == smsp_pkg::SMSP_IDLE) |-> o_sck == q.cpol)
      else $error("master clock not at idle level");

   byte_time_a: assert property (
      m_fast_s |-> ##31 (q.state == smsp_pkg::SMSP_RUN)
      ##1 (q.state == smsp_pkg::SMSP_IDLE && q.transfer_done_flag))
      else $error("fast master byte not 32 cycles");

   first_bit_a: assert property (
      (m_start_s ##0 !q.cpha) |-> o_mosi == q.sh[7])
      else $error("first master bit not msb");

   done_set_a: assert property (
      (q.state == smsp_pkg::SMSP_RUN && fin) |=> q.transfer_done_flag)
      else $error("done flag not set after byte");

   irq_gate_a: assert property (
      (n.transfer_done_flag && n.transfer_irq_enable && !i_cpu_irq_mask) |=> o_irq)
      else $error("interrupt missing");

   wr_inhibit_a: assert property (
      (inhibit && i_dr_write && q.master_select && !edge_ev) |=>
      $stable(q.sh) && q.state == $past(q.state))
      else $error("data write taken while done set");

   collision_a: assert property (
      (i_dr_write && !inhibit && q.state == smsp_pkg::SMSP_RUN &&
       !edge_ev) |=> q.write_collision_flag && $stable(q.sh) && !$rose(o_irq))
      else $error("collision not flagged");

   mode_fault_a: assert property (
      (q.master_select && q.periph_enable && !ss_int) |=> q.mode_fault_flag && !q.master_select && !q.periph_enable
      ##1 !q.sck_oe)
      else $error("mode fault not taken");

   overrun_a: assert property (
      (fin && q.transfer_done_flag && !clr_done) |=> q.overrun_flag && !q.push)
      else $error("overrun not flagged");

   slave_hold_a: assert property (
      (slave_on && ss_int && !i_dr_write && !i_ctrl_write) |=>
      $stable(q.sh) && $stable(q.edges))
      else $error("deselected slave changed state");

   done_clear_a: assert property (
      (q.master_select && q.transfer_done_flag && q.csr_seen && i_dr_read && !fin) |=> !q.transfer_done_flag)
      else $error("done flag not cleared");

endmodule

// [tb/smsp_peer.sv]
// Far-side serial device model: slave to a master port, master to a slave
`timescale 1ns/1ns
module smsp_peer (
   input wire logic i_clk,
   input wire logic i_dut_master,
   input wire logic i_cpol,
   input wire logic i_cpha,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_miso,
   output logic o_sck,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_miso,
   output logic o_miso_oe,
   output logic o_ss_n
);
   // Four CPU cycles a half, well below half the CPU rate
   localparam int HALF = 4;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   int out_q;
   logic sck_prev;
   logic busy;

   initial begin
      o_sck = 1'b0;
      o_mosi = 1'b0;
      o_mosi_oe = 1'b0;
      o_miso = 1'b0;
      o_ss_n = 1'b1;
      busy = 1'b0;
      out_q = 8;
      rx_q = 8'h00;
      sck_prev = 1'b0;
   end

   assign o_miso_oe = i_dut_master;

   // Slave side, shifting on the master clock
   always @(posedge i_clk) begin
      sck_prev <= i_sck;
      if (!busy) o_sck <= i_cpol;
      if (i_dut_master && i_sck !== sck_prev) begin
         if ((i_sck != i_cpol) ^ i_cpha) begin
            rx_q <= {rx_q[6:0], i_mosi};
         end else if (out_q < 8) begin
            o_miso <= tx_q[7 - out_q];
            out_q <= out_q + 1;
         end
      end
   end

   task automatic load(input logic [7:0] b);
      tx_q = b;
      out_q = i_cpha ? 0 : 1;
      o_miso = b[7];
   endtask

   // Select low only across one byte
   task automatic mxfer(input logic [7:0] b, input logic sel,
                        output logic [7:0] r);
      busy = 1'b1;
      o_ss_n <= ~sel;
      o_mosi_oe <= 1'b1;
      repeat (HALF) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         if (!i_cpha) o_mosi <= b[7 - i];
         repeat (HALF) @(posedge i_clk);
         o_sck <= ~i_cpol;
         if (i_cpha) o_mosi <= b[7 - i];
         else r[7 - i] = i_miso;
         repeat (HALF) @(posedge i_clk);
         o_sck <= i_cpol;
         if (i_cpha) r[7 - i] = i_miso;
      end
      repeat (HALF) @(posedge i_clk);
      o_ss_n <= 1'b1;
      o_mosi_oe <= 1'b0;
      busy = 1'b0;
   endtask
endmodule

// [tb/smsp_port_tb.sv]
// Self-checking bench of the serial master/slave port
`timescale 1ns/1ns
module smsp_port_tb;
   logic clk, arst_n, flip, mask, rx_ready;
   logic [4:0] stb;
   logic [9:0] cfgv;
   logic [7:0] wdata, rx_data, r8;
   logic rx_valid, done, overrun_flag, write_collision_flag, mode_fault_flag, mact, irq;
   logic sck, sck_oe, mosi, mosi_oe, miso, miso_oe;
   logic p_sck, p_mosi, p_mosi_oe, p_miso, p_miso_oe, p_ss_n;
   logic sck_w, mosi_w, miso_w;
   int checks, mismatches, cyc, n, k;

   assign sck_w = sck_oe ? sck : p_sck;
   assign mosi_w = mosi_oe ? mosi : (p_mosi_oe ? p_mosi : flip);
   assign miso_w = miso_oe ? miso : (p_miso_oe ? p_miso : flip);

   smsp_port DUT (
      .i_sys_clk(clk),
      .i_arst_n(arst_n),
      .i_ctrl_write(stb[0]),
      .i_master_select(cfgv[0]),
      .i_periph_enable(cfgv[1]),
      .i_transfer_irq_enable(cfgv[2]),
      .i_cpol(cfgv[3]),
      .i_cpha(cfgv[4]),
      .i_clock_rate_sel(cfgv[7:5]),
      .i_csr_write(stb[1]),
      .i_select_sw_manage(cfgv[8]),
      .i_select_sw_level(cfgv[9]),
      .i_csr_access(stb[2]),
      .i_dr_write(stb[3]),
      .i_dr_wdata(wdata),
      .i_dr_read(stb[4]),
      .i_cpu_irq_mask(mask),
      .i_rx_ready(rx_ready),
      .o_rx_valid(rx_valid),
      .o_rx_data(rx_data),
      .o_transfer_done_flag(done),
      .o_overrun_flag(overrun_flag),
      .o_write_collision_flag(write_collision_flag),
      .o_mode_fault_flag(mode_fault_flag),
      .o_master_active(mact),
      .o_irq(irq),
      .i_ss_n(p_ss_n),
      .i_sck(sck_w),
      .o_sck(sck),
      .o_sck_oe(sck_oe),
      .i_mosi(mosi_w),
      .o_mosi(mosi),
      .o_mosi_oe(mosi_oe),
      .i_miso(miso_w),
      .o_miso(miso),
      .o_miso_oe(miso_oe)
   );

   smsp_peer peer (
      .i_clk(clk),
      .i_dut_master(sck_oe),
      .i_cpol(cfgv[3]),
      .i_cpha(cfgv[4]),
      .i_sck(sck_w),
      .i_mosi(mosi_w),
      .i_miso(miso_w),
      .o_sck(p_sck),
      .o_mosi(p_mosi),
      .o_mosi_oe(p_mosi_oe),
      .o_miso(p_miso),
      .o_miso_oe(p_miso_oe),
      .o_ss_n(p_ss_n)
   );

   // ---------------------------------------------------------------
   // Clock and run limit
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      flip <= ~flip;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         end_sim;
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic pulse(input logic [4:0] m, input logic [7:0] d);
      @(posedge clk);
      stb <= m;
      wdata <= d;
      @(posedge clk);
      stb <= 5'h00;
      #1;
   endtask

   task automatic cfg(input logic m, input logic sm, input logic pol,
                      input logic pha, input logic [2:0] r);
      @(posedge clk);
      cfgv <= {m, sm, r, pha, pol, 1'b1, 1'b1, m};
      pulse(5'h02, 8'h00);
      pulse(5'h04, 8'h00);
      pulse(5'h01, 8'h00);
      tick(2);
   endtask

   task automatic wait_done;
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic clr;
      pulse(5'h04, 8'h00);
      pulse(5'h10, 8'h00);
      tick(1);
   endtask

   task automatic pop(input logic [7:0] exp);
      tick(1);
      chk("rx valid", rx_valid, 16'h0001);
      chk("rx data", rx_data, exp);
      @(posedge clk);
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      #1;
   endtask

   task automatic m_xfer(input logic [7:0] tx, input logic [7:0] rsp,
                         input int exp_n);
      peer.load(rsp);
      pulse(5'h08, tx);
      wait_done;
      if (exp_n > 0) chk("cycles", 16'(n), 16'(exp_n));
      // Peer sees a last trailing edge one cycle after done rises
      tick(1);
      chk("peer rx", peer.rx_q, tx);
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      flip = 1'b0;
      cyc = 0;
      stb = 5'h00;
      cfgv = 10'h000;
      wdata = 8'h00;
      mask = 1'b0;
      rx_ready = 1'b0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      tick(3);
      chk("flags", {done, overrun_flag, write_collision_flag, mode_fault_flag, mact, irq, rx_valid}, 0);
      chk("pins", {sck, sck_oe, mosi_oe, miso_oe}, 0);
      $display("Test reset finished");
      peer.o_ss_n <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         k = (i == 4) ? 5 : i;
         cfg(1'b1, 1'b1, i[0], i[1], (i == 4) ? 3'h7 : 3'(i));
         chk("idle sck", sck, 16'(i[0]));
         chk("sck oe", sck_oe, 16'h0001);
         m_xfer(8'ha5 ^ 8'(i), 8'h3c + 8'(i), 1 + (32 << k));
         pop(8'h3c + 8'(i));
         chk("irq", irq, 16'h0001);
         chk("no fault", mode_fault_flag, 16'h0000);
         clr;
         chk("done clear", done, 16'h0000);
      end
      $display("Test master modes finished");
      cfg(1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
      m_xfer(8'h81, 8'h42, 0);
      pulse(5'h08, 8'h55);
      tick(80);
      pop(8'h42);
      chk("no second byte", rx_valid, 16'h0000);
      @(posedge clk);
      mask <= 1'b1;
      tick(3);
      chk("irq masked", irq, 16'h0000);
      mask <= 1'b0;
      clr;
      peer.load(8'h24);
      pulse(5'h08, 8'hc3);
      tick(5);
      pulse(5'h08, 8'h18);
      tick(2);
      chk("collision", write_collision_flag, 16'h0001);
      chk("no irq", irq, 16'h0000);
      wait_done;
      chk("kept byte", peer.rx_q, 8'hc3);
      pop(8'h24);
      clr;
      chk("flags clear", {done, write_collision_flag}, 16'h0000);
      $display("Test inhibit and collision finished");
      m_xfer(8'h01, 8'h61, 0);
      clr;
      m_xfer(8'h02, 8'h62, 0);
      clr;
      peer.load(8'h63);
      pulse(5'h08, 8'h03);
      tick(100);
      chk("stall on full", done, 16'h0000);
      pop(8'h61);
      wait_done;
      chk("resumed", done, 16'h0001);
      pop(8'h62);
      pop(8'h63);
      clr;
      chk("drained", rx_valid, 16'h0000);
      $display("Test buffer finished");
      peer.o_ss_n <= 1'b1;
      cfg(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
      chk("master on", mact, 16'h0001);
      @(posedge clk);
      peer.o_ss_n <= 1'b0;
      tick(5);
      chk("fault", {mode_fault_flag, mact, sck_oe}, 16'h0004);
      chk("fault irq", irq, 16'h0001);
      @(posedge clk);
      peer.o_ss_n <= 1'b1;
      pulse(5'h01, 8'h00);
      tick(2);
      chk("held off", mact, 16'h0000);
      cfg(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
      chk("recovered", {mode_fault_flag, mact}, 16'h0001);
      $display("Test mode fault finished");
      cfg(1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
      peer.mxfer(8'h77, 1'b0, r8);
      tick(20);
      chk("deselected", done, 16'h0000);
      pulse(5'h08, 8'h96);
      peer.mxfer(8'h5a, 1'b1, r8);
      wait_done;
      chk("slave tx", r8, 8'h96);
      pop(8'h5a);
      peer.mxfer(8'h11, 1'b1, r8);
      tick(20);
      chk("overrun", overrun_flag, 16'h0001);
      chk("byte lost", rx_valid, 16'h0000);
      pulse(5'h04, 8'h00);
      pulse(5'h08, 8'h00);
      tick(2);
      chk("slave clear", {done, overrun_flag}, 16'h0000);
      $display("Test slave finished");
      end_sim;
   end
endmodule
